// *** rtl/fbip_pkg.sv ***
// Summary of operation
// - An output-direction pin in GPIO function is driven from its bit of the port data register.
// - Reading the data register returns the written value for output pins.
// - Reading the data register returns the sampled pin level for input pins.
// - Data bits 3 to 0 map to pins 3 to 0, with 0 as low and 1 as high.
// - The direction register holds one bit per pin, 0 output and 1 input, reset to 0.
// - In output mode the two-bit code selects hi-z, P open drain, N open drain or push-pull.
// - In input mode the code selects hi-z, pull-down, pull-up or hi-z input.
// - The stored code is interpreted by the pin's current direction bit.
// - The config register is two bytes, bit 0 per pin low, bit 1 per pin high, word at low.
// - The config register resets to zero, so every pin starts as hi-z output.
// - Data and direction registers are byte-wide, 8-bit access only, read-write, reset 0.
// - The function-select register is two bytes, byte or word access, read-write, reset 0.
// - Each pin's function code routes it to GPIO, converter, serial or UART-timer use.
package fbip_pkg;

    // ************************************************************
    // Register indices, byte address is four times the index
    // ************************************************************
    localparam logic [15:0] FBIP_IDX_DATA  = 16'hF220;
    localparam logic [15:0] FBIP_IDX_DIR   = 16'hF221;
    localparam logic [15:0] FBIP_IDX_CFG_L = 16'hF222;
    localparam logic [15:0] FBIP_IDX_CFG_H = 16'hF223;
    localparam logic [15:0] FBIP_IDX_FSL_L = 16'hF224;
    localparam logic [15:0] FBIP_IDX_FSL_H = 16'hF225;

    // ************************************************************
    // Reset values and field positions
    // ************************************************************
    localparam logic [7:0]  FBIP_RST_BYTE  = 8'h00;
    localparam int          FBIP_LO_LSB    = 0;
    localparam int          FBIP_HI_LSB    = 8;
    localparam logic        FBIP_DIR_OUT   = 1'b0;
    localparam logic        FBIP_DIR_IN    = 1'b1;

    // ************************************************************
    // Avalon response codes
    // ************************************************************
    localparam logic [1:0]  FBIP_RESP_OK   = 2'h0;
    localparam logic [1:0]  FBIP_RESP_DEC  = 2'h3;

    // ************************************************************
    // Codes and carriers
    // ************************************************************
    typedef enum logic [1:0] {
        FBIP_CFG_HIZ  = 2'b00,
        FBIP_CFG_PCH  = 2'b01,
        FBIP_CFG_NCH  = 2'b10,
        FBIP_CFG_CMOS = 2'b11
    } fbip_cfg_t;

    typedef enum logic [1:0] {
        FBIP_FN_GPIO   = 2'b00,
        FBIP_FN_RCADC  = 2'b01,
        FBIP_FN_SERIAL = 2'b10,
        FBIP_FN_UART   = 2'b11
    } fbip_fsel_t;

    typedef struct packed {
        logic out;
        logic oe;
        logic pull_up;
        logic pull_dn;
    } fbip_pad_t;

    typedef struct packed {
        logic rc;
        logic serial;
        logic uart;
    } fbip_alt_t;

endpackage

// *** rtl/fbip_sync.sv ***
module fbip_sync #(
    parameter int W = 4
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_q;

    // ************************************************************
    // Two-flop synchroniser
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_q <= '0;
            q_o    <= '0;
        end
        else
        begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end

endmodule

// *** rtl/fbip_pad.sv ***
module fbip_pad
    import fbip_pkg::*;
(
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               dir_i,
    input  wire fbip_pkg::fbip_cfg_t cfg_i,
    input  wire logic               data_i,
    output fbip_pkg::fbip_pad_t     pad_o
);

    fbip_pad_t pad_d;

    // ************************************************************
    // Driver decode
    // ************************************************************
    always_comb
    begin
        pad_d = '0;
        if (dir_i == FBIP_DIR_OUT)
        begin
            unique case (cfg_i)
                FBIP_CFG_HIZ:  pad_d = '0;
                FBIP_CFG_PCH:  begin pad_d.out = 1'b1; pad_d.oe = data_i; end
                FBIP_CFG_NCH:  begin pad_d.out = 1'b0; pad_d.oe = ~data_i; end
                FBIP_CFG_CMOS: begin pad_d.out = data_i; pad_d.oe = 1'b1; end
            endcase
        end
        else
        begin
            pad_d.pull_dn = (cfg_i == FBIP_CFG_PCH);
            pad_d.pull_up = (cfg_i == FBIP_CFG_NCH);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pad_o <= '0;
        else
            pad_o <= pad_d;
    end

endmodule

// *** rtl/fbip_top.sv ***
module fbip_top
    import fbip_pkg::*;
#(
    parameter int N = 4
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic [17:0]          avs_address_i,
    input  wire logic                 avs_read_i,
    input  wire logic                 avs_write_i,
    input  wire logic [31:0]          avs_writedata_i,
    input  wire logic [3:0]           avs_byteenable_i,
    output logic      [31:0]          avs_readdata_o,
    output logic                      avs_waitrequest_o,
    output logic      [1:0]           avs_response_o,
    input  wire logic [N-1:0]         pin_i,
    output logic      [N-1:0]         pin_o,
    output logic      [N-1:0]         pin_oe_o,
    output logic      [N-1:0]         pull_up_o,
    output logic      [N-1:0]         pull_dn_o,
    input  wire fbip_pkg::fbip_alt_t [N-1:0] alt_data_i,
    output fbip_pkg::fbip_fsel_t [N-1:0]     func_sel_o,
    output logic      [N-1:0]         pin_level_o
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [7:0]       data_q;
    logic [7:0]       dir_q;
    logic [7:0]       cfg_lo_q;
    logic [7:0]       cfg_hi_q;
    logic [7:0]       fsl_lo_q;
    logic [7:0]       fsl_hi_q;
    logic             done_q;
    logic             req;
    logic             take;
    logic [15:0]      idx;
    logic             sel_data;
    logic             sel_dir;
    logic             sel_cfg_l;
    logic             sel_cfg_h;
    logic             sel_fsl_l;
    logic             sel_fsl_h;
    logic             mapped;
    logic             wr_b0;
    logic             wr_b1;
    logic [7:0]       wbyte0;
    logic [7:0]       wbyte1;
    logic             wr_data;
    logic             wr_dir;
    logic             wr_cfg_lo;
    logic             wr_cfg_hi_b;
    logic             wr_cfg_hi_w;
    logic             wr_fsl_lo;
    logic             wr_fsl_hi_b;
    logic             wr_fsl_hi_w;
    logic [N-1:0]     level_sync;
    logic [N-1:0]     data_rb;
    logic [N-1:0]     drive_val;
    logic [31:0]      rdata_d;
    logic [31:0]      rdata_q;
    logic [1:0]       resp_d;
    logic [1:0]       resp_q;
    fbip_pad_t [N-1:0] pad;
    fbip_cfg_t [N-1:0] cfg_code;
    fbip_fsel_t [N-1:0] fsel_code;

    // ************************************************************
    // Bus handshake
    // ************************************************************
    assign req  = avs_read_i | avs_write_i;
    assign take = req & done_q;

    // One wait cycle per access, answer on second edge
    assign avs_waitrequest_o = req & ~done_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            done_q <= 1'b0;
        else
            done_q <= req & ~done_q;
    end

    // ************************************************************
    // Address decode
    // ************************************************************
    assign idx       = avs_address_i[17:2];
    assign sel_data  = (idx == FBIP_IDX_DATA);
    assign sel_dir   = (idx == FBIP_IDX_DIR);
    assign sel_cfg_l = (idx == FBIP_IDX_CFG_L);
    assign sel_cfg_h = (idx == FBIP_IDX_CFG_H);
    assign sel_fsl_l = (idx == FBIP_IDX_FSL_L);
    assign sel_fsl_h = (idx == FBIP_IDX_FSL_H);

    assign mapped = sel_data | sel_dir | sel_cfg_l | sel_cfg_h
                  | sel_fsl_l | sel_fsl_h;

    assign wr_b0  = avs_write_i & take & avs_byteenable_i[0];
    assign wr_b1  = avs_write_i & take & avs_byteenable_i[1];
    assign wbyte0 = avs_writedata_i[FBIP_LO_LSB +: 8];
    assign wbyte1 = avs_writedata_i[FBIP_HI_LSB +: 8];

    // ************************************************************
    // Per-register write strobes
    // ************************************************************
    assign wr_data     = wr_b0 & sel_data;
    assign wr_dir      = wr_b0 & sel_dir;
    assign wr_cfg_lo   = wr_b0 & sel_cfg_l;
    assign wr_cfg_hi_b = wr_b0 & sel_cfg_h;
    assign wr_cfg_hi_w = wr_b1 & sel_cfg_l;
    assign wr_fsl_lo   = wr_b0 & sel_fsl_l;
    assign wr_fsl_hi_b = wr_b0 & sel_fsl_h;
    assign wr_fsl_hi_w = wr_b1 & sel_fsl_l;

    // ************************************************************
    // Data register
    // ************************************************************
    // byte lane only
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            data_q <= FBIP_RST_BYTE;
        else if (wr_data)
            data_q <= wbyte0;
    end

    // ************************************************************
    // Direction register
    // ************************************************************
    // reset to output
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dir_q <= FBIP_RST_BYTE;
        else if (wr_dir)
            dir_q <= wbyte0;
    end

    // ************************************************************
    // Pad configuration register
    // ************************************************************
    // reset to hi-z output
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cfg_lo_q <= FBIP_RST_BYTE;
        else if (wr_cfg_lo)
            cfg_lo_q <= wbyte0;
    end

    // byte or word at low address
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cfg_hi_q <= FBIP_RST_BYTE;
        else if (wr_cfg_hi_b)
            cfg_hi_q <= wbyte0;
        else if (wr_cfg_hi_w)
            cfg_hi_q <= wbyte1;
    end

    // ************************************************************
    // Function-select register
    // ************************************************************
    // byte or word access
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            fsl_lo_q <= FBIP_RST_BYTE;
        else if (wr_fsl_lo)
            fsl_lo_q <= wbyte0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            fsl_hi_q <= FBIP_RST_BYTE;
        else if (wr_fsl_hi_b)
            fsl_hi_q <= wbyte0;
        else if (wr_fsl_hi_w)
            fsl_hi_q <= wbyte1;
    end

    // ************************************************************
    // Per-pin codes
    // ************************************************************
    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            cfg_code[i]  = fbip_cfg_t'({cfg_hi_q[i], cfg_lo_q[i]});
            fsel_code[i] = fbip_fsel_t'({fsl_hi_q[i], fsl_lo_q[i]});
        end
    end

    // ************************************************************
    // Input synchroniser
    // ************************************************************
    // two-flop input path
    fbip_sync #(
        .W (N)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (pin_i),
        .q_o   (level_sync)
    );

    assign pin_level_o = level_sync;

    // ************************************************************
    // Data readback
    // ************************************************************
    always_comb
    begin
        data_rb = '0;
        for (int i = 0; i < N; i++)
        begin
            data_rb[i] = dir_q[i] ? level_sync[i] : data_q[i];
        end
    end

    // ************************************************************
    // Drive value select
    // ************************************************************
    always_comb
    begin
        drive_val = '0;
        for (int i = 0; i < N; i++)
        begin
            unique case (fsel_code[i])
                FBIP_FN_GPIO:   drive_val[i] = data_q[i];
                FBIP_FN_RCADC:  drive_val[i] = alt_data_i[i].rc;
                FBIP_FN_SERIAL: drive_val[i] = alt_data_i[i].serial;
                FBIP_FN_UART:   drive_val[i] = alt_data_i[i].uart;
            endcase
        end
    end

    // ************************************************************
    // Read mux
    // ************************************************************
    // upper bits read zero
    always_comb
    begin
        rdata_d = '0;
        resp_d  = FBIP_RESP_OK;
        if (sel_data)
            rdata_d[N-1:0] = data_rb;
        else if (sel_dir)
            rdata_d[N-1:0] = dir_q[N-1:0];
        else if (sel_cfg_l)
        begin
            rdata_d[FBIP_LO_LSB +: N] = cfg_lo_q[N-1:0];
            rdata_d[FBIP_HI_LSB +: N] = cfg_hi_q[N-1:0];
        end
        else if (sel_cfg_h)
            rdata_d[N-1:0] = cfg_hi_q[N-1:0];
        else if (sel_fsl_l)
        begin
            rdata_d[FBIP_LO_LSB +: N] = fsl_lo_q[N-1:0];
            rdata_d[FBIP_HI_LSB +: N] = fsl_hi_q[N-1:0];
        end
        else if (sel_fsl_h)
            rdata_d[N-1:0] = fsl_hi_q[N-1:0];
        if (!mapped)
            resp_d = FBIP_RESP_DEC;
    end

    // ************************************************************
    // Read data capture
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdata_q <= '0;
        else if (req && !done_q)
            rdata_q <= avs_read_i ? rdata_d : '0;
    end

    // ************************************************************
    // Response capture
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            resp_q <= FBIP_RESP_OK;
        else if (req && !done_q)
            resp_q <= resp_d;
    end

    assign avs_readdata_o = rdata_q;
    assign avs_response_o = resp_q;

    // ************************************************************
    // Pad drivers
    // ************************************************************
    for (genvar g = 0; g < N; g++)
    begin : g_pad
        fbip_pad u_pad (
            .clk_i  (clk_i),
            .rst_i  (rst_i),
            .dir_i  (dir_q[g]),
            .cfg_i  (cfg_code[g]),
            .data_i (drive_val[g]),
            .pad_o  (pad[g])
        );
    end

    // ************************************************************
    // Pin drive outputs
    // ************************************************************
    always_comb
    begin
        pin_o    = '0;
        pin_oe_o = '0;
        for (int i = 0; i < N; i++)
        begin
            pin_o[i]    = pad[i].out;
            pin_oe_o[i] = pad[i].oe;
        end
    end

    // ************************************************************
    // Pull outputs
    // ************************************************************
    always_comb
    begin
        pull_up_o = '0;
        pull_dn_o = '0;
        for (int i = 0; i < N; i++)
        begin
            pull_up_o[i] = pad[i].pull_up;
            pull_dn_o[i] = pad[i].pull_dn;
        end
    end

    // ************************************************************
    // Function-select outputs
    // ************************************************************
    assign func_sel_o = fsel_code;

endmodule

// *** dv/fbip_sva.sv ***
module fbip_sva
    import fbip_pkg::*;
#(
    parameter int N = 4
) (
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic [17:0]                 avs_address_i,
    input  wire logic                        avs_read_i,
    input  wire logic                        avs_write_i,
    input  wire logic                        avs_waitrequest_o,
    input  wire logic [1:0]                  avs_response_o,
    input  wire logic [N-1:0]                pin_i,
    input  wire logic [N-1:0]                pin_oe_o,
    input  wire logic [N-1:0]                pull_up_o,
    input  wire logic [N-1:0]                pull_dn_o,
    input  wire fbip_pkg::fbip_fsel_t [N-1:0] func_sel_o,
    input  wire logic [N-1:0]                pin_level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import fbip_pkg::*;
    logic req;
    logic mapped;
    assign req    = avs_read_i | avs_write_i;
    assign mapped = avs_address_i[17:2] >= FBIP_IDX_DATA
                 && avs_address_i[17:2] <= FBIP_IDX_FSL_H;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ************************************************************
    // Bus handshake and responses
    // ************************************************************
    a_wait_once: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("waitrequest held too long");
    a_wait_idle: assert property (!req |-> !avs_waitrequest_o)
        else $error("waitrequest while idle");
    a_resp_mapped: assert property (req && !avs_waitrequest_o && mapped
        |-> avs_response_o == FBIP_RESP_OK)
        else $error("mapped access not ok");
    a_resp_unmap: assert property (req && !avs_waitrequest_o && !mapped
        |-> avs_response_o == FBIP_RESP_DEC)
        else $error("unmapped access not refused");
    // ************************************************************
    // Pads and input sampling
    // ************************************************************
    a_pull_excl: assert property ((pull_up_o & pull_dn_o) == '0)
        else $error("both pulls on");
    a_pull_drive: assert property (((pull_up_o | pull_dn_o) & pin_oe_o) == '0)
        else $error("pull while driving");
    a_sync_two: assert property (!$past(rst_i) && !$past(rst_i, 2)
        |-> pin_level_o == $past(pin_i, 2))
        else $error("pin level not two cycles behind");
    a_pull_cause: assert property (!$past(rst_i) && !$past(rst_i, 2)
        && ($changed(pull_up_o) || $changed(pull_dn_o))
        |-> $past(avs_write_i && !avs_waitrequest_o, 2))
        else $error("pull changed without write");
    a_fsel_cause: assert property (!$past(rst_i) && $changed(func_sel_o)
        |-> $past(avs_write_i && !avs_waitrequest_o))
        else $error("function select changed without write");
    c_read: cover property (avs_read_i && !avs_waitrequest_o);
    c_unmap: cover property (req && !avs_waitrequest_o && !mapped);
    c_pull: cover property (|pull_up_o);
    c_drive: cover property (|pin_oe_o);
endmodule

// *** dv/fbip_pins.sv ***
module fbip_pins #(
    parameter int N = 4
) (
    input  wire logic         clk_i,
    input  wire logic [N-1:0] drv_i,
    input  wire logic [N-1:0] oe_i,
    input  wire logic [N-1:0] pu_i,
    input  wire logic [N-1:0] pd_i,
    input  wire logic [N-1:0] ext_en_i,
    input  wire logic [N-1:0] ext_val_i,
    output logic      [N-1:0] lvl_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [N-1:0] float_q = '0;
    // ************************************************************
    // Undriven pins without a pull wander every cycle
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        float_q <= ~float_q;
    end
    assign lvl_o = (oe_i & drv_i) | (~oe_i & ext_en_i & ext_val_i)
                 | (~oe_i & ~ext_en_i & (pu_i | (~pd_i & float_q)));
endmodule

// *** dv/fbip_tb_top.sv ***
module fbip_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import fbip_pkg::*;
    localparam int N = 4;
    logic clk_i, rst_i, rd, wr, wreq;
    logic [17:0] adr;
    logic [31:0] wdat, rdat, q;
    logic [3:0] be;
    logic [1:0] resp, r;
    logic [N-1:0] lvl, drv, oe, pu, pd, ext_en, ext_val, pin_lvl;
    fbip_alt_t [N-1:0] alt;
    fbip_fsel_t [N-1:0] fsel;
    logic [7:0] dv, cl, ch, dt, fl, fh;
    logic [3:0] ex;
    logic [23:0] pe;
    int bad_count, checked;
    fbip_top #(.N(N)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .avs_response_o(resp),
        .pin_i(lvl), .pin_o(drv), .pin_oe_o(oe), .pull_up_o(pu), .pull_dn_o(pd),
        .alt_data_i(alt), .func_sel_o(fsel), .pin_level_o(pin_lvl));
    fbip_pins #(.N(N)) i_pins (.clk_i(clk_i), .drv_i(drv), .oe_i(oe), .pu_i(pu),
        .pd_i(pd), .ext_en_i(ext_en), .ext_val_i(ext_val), .lvl_o(lvl));
    // ************************************************************
    // Bus, compare, reset-check and closing tasks
    // ************************************************************
    task automatic bus(input logic w, input logic [15:0] ix, input logic [31:0] d,
                       input logic [3:0] b);
        int n;
        n = 0;
        @(posedge clk_i);
        adr <= {ix, 2'b00};
        wr <= w;
        rd <= ~w;
        wdat <= d;
        be <= b;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wreq !== 1'b0 && n < 50);
        q = rdat;
        r = resp;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 50)
            bad_count++;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic conclude();
        $display("Counts: %0d checked, %0d bad", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic regs_zero();
        for (int i = 0; i < 6; i++)
        begin
            bus(1'b0, FBIP_IDX_DATA + 16'(i), 32'h0, 4'h1);
            chk("reset reg", 32'h0, {24'h0, q[7:0]});
            chk("reset resp", {30'h0, FBIP_RESP_OK}, {30'h0, r});
        end
        chk("reset pads", 32'h0, {20'h0, oe, pu, pd});
    endtask
    // ************************************************************
    // Expected pads and function codes
    // ************************************************************
    function automatic logic [23:0] pad_exp(input logic [3:0] dir, input logic [3:0] lo,
        input logic [3:0] hi, input logic [3:0] dat, input logic [3:0] sl, input logic [3:0] sh,
        input fbip_alt_t [N-1:0] al);
        logic [3:0] e_oe, e_ou, e_pu, e_pd;
        logic [7:0] e_fs;
        logic d;
        {e_oe, e_ou, e_pu, e_pd, e_fs} = 24'h0;
        for (int i = 0; i < 4; i++)
        begin
            e_fs[2*i+:2] = {sh[i], sl[i]};
            d = {sh[i], sl[i]} == 2'b00 ? dat[i] : {sh[i], sl[i]} == 2'b01 ? al[i].rc
                : {sh[i], sl[i]} == 2'b10 ? al[i].serial : al[i].uart;
            e_pu[i] = dir[i] & hi[i] & ~lo[i];
            e_pd[i] = dir[i] & ~hi[i] & lo[i];
            e_oe[i] = ~dir[i] & (lo[i] ? (hi[i] | d) : (hi[i] & ~d));
            e_ou[i] = lo[i] & (~hi[i] | d);
        end
        return {e_oe, e_ou, e_pu, e_pd, e_fs};
    endfunction
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial
    begin
        #100000;
        bad_count++;
        conclude();
    end
    initial
    begin
        {rst_i, rd, wr, adr, wdat, be, alt, ext_en, ext_val} = {1'b1, 76'h0};
        bad_count = 0;
        checked = 0;
        void'($urandom(93));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        regs_zero();
        $display("Test reset done");
        for (int k = 0; k < 24; k++)
        begin
            {dv, cl, ch, dt, fl, fh} = {16'($urandom), $urandom};
            ex = 4'($urandom);
            if (k < 2)
            begin
                {cl, ch, fl, fh} = 32'hFAFC0000;
                dv = (k == 1) ? 8'hFF : 8'h00;
            end
            alt <= 12'($urandom);
            ext_val <= ex;
            ext_en <= dv[3:0];
            bus(1'b1, FBIP_IDX_DATA, {24'h0, dt}, 4'h1);
            bus(1'b1, FBIP_IDX_DIR, {24'h0, dv}, 4'h1);
            if (k % 2 == 1)
                bus(1'b1, FBIP_IDX_CFG_L, {16'h0, ch, cl}, 4'h3);
            else
            begin
                bus(1'b1, FBIP_IDX_CFG_L, {24'h0, cl}, 4'h1);
                bus(1'b1, FBIP_IDX_CFG_H, {24'h0, ch}, 4'h1);
            end
            bus(1'b1, FBIP_IDX_FSL_L, {16'h0, fh, fl}, 4'h3);
            bus(1'b0, FBIP_IDX_DATA, 32'h0, 4'h1);
            chk("data", {28'h0, dv[3:0] & ex | ~dv[3:0] & dt[3:0]}, q & 32'hFF);
            bus(1'b0, FBIP_IDX_DIR, 32'h0, 4'h1);
            chk("dir", {28'h0, dv[3:0]}, q & 32'hFF);
            bus(1'b0, FBIP_IDX_CFG_L, 32'h0, 4'h3);
            chk("cfg word", {20'h0, ch[3:0], 4'h0, cl[3:0]}, q & 32'hFFFF);
            bus(1'b0, FBIP_IDX_CFG_H, 32'h0, 4'h1);
            chk("cfg high", {28'h0, ch[3:0]}, q & 32'hFF);
            bus(1'b0, FBIP_IDX_FSL_L, 32'h0, 4'h3);
            chk("fsel word", {20'h0, fh[3:0], 4'h0, fl[3:0]}, q & 32'hFFFF);
            pe = pad_exp(dv[3:0], cl[3:0], ch[3:0], dt[3:0], fl[3:0], fh[3:0], alt);
            chk("pad oe", {28'h0, pe[23:20]}, {28'h0, oe});
            chk("drive", {28'h0, pe[19:16] & pe[23:20]}, {28'h0, drv & pe[23:20]});
            chk("pulls", {24'h0, pe[15:8]}, {24'h0, pu, pd});
            chk("func sel", {24'h0, pe[7:0]}, {24'h0, fsel});
            chk("level", {28'h0, dv[3:0] & ex}, {28'h0, pin_lvl & dv[3:0]});
        end
        $display("Test pads done");
        bus(1'b0, 16'hF226, 32'h0, 4'h1);
        chk("unmapped data", 32'h0, q);
        chk("unmapped resp", {30'h0, FBIP_RESP_DEC}, {30'h0, r});
        bus(1'b1, 16'hF21F, 32'hFF, 4'h1);
        chk("unmapped wr resp", {30'h0, FBIP_RESP_DEC}, {30'h0, r});
        bus(1'b1, FBIP_IDX_DIR, 32'h0F0F, 4'h2);
        bus(1'b0, FBIP_IDX_DIR, 32'h0, 4'h1);
        chk("dir lane", {28'h0, dv[3:0]}, q & 32'hFF);
        $display("Test refuse done");
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        regs_zero();
        $display("Test second reset done");
        conclude();
    end
endmodule
bind fbip_top fbip_sva #(.N(N)) i_sva (.clk_i, .rst_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_waitrequest_o, .avs_response_o, .pin_i, .pin_oe_o, .pull_up_o,
    .pull_dn_o, .func_sel_o, .pin_level_o);
